// ---- design/tcp_prefetch_engine.sv ----
`timescale 1ns/10ps
//
// Contract
// - Consumer index moves past a command only once it has been read.
// - Sync completes only after every earlier command fully finished.
// - Non-zero reserved fields of prefetch commands or illegal values raise the illegal command error.
// - Substream valid flag set means a substream id comes with the command.
// - Security select on secure queue picks secure stream when secure side exists.
// - Security select set on non-secure queue makes any prefetch command illegal.
// - Virtual address fields fill bits 63..12, low twelve bits zero.
// - Physical/intermediate addresses use bits 51..12 only, others zero.
// - Out-of-range parameter makes the command have no effect.
// - Stream ids checked against secure or non-secure width; substream against its width.
// - Out-of-range prefetch parameters raise no error; out-of-range addresses skipped.
// - Address range test per stage 1 and stage 2 sizes.
// - Substream flag ignored when substreams absent or one context only.
// - Prefetch to invalid entries or faulting addresses fails silently.
// - With translation disabled, prefetches are consumed and do nothing.
// - Config prefetch through both stages with flag update sets access flag.
// - Address prefetch walks base plus n pages for n below two to size.
// - Non-zero stride raises the illegal command error.
// - Non-secure attribute forwarded only for secure stage-2-input streams.
// - Address prefetch capped at a fixed count of translation operations.
// - Address prefetch with flag update marks access and acts as speculative read.
module tcp_prefetch_engine (
    // Clock and reset
    input  wire logic                     i_mclk,
    input  wire logic                     i_srst,
    // Command queue head
    input  wire logic                     i_cmd_valid,
    input  wire logic [tcp_pkg::CMD_W-1:0] i_cmd_data,
    input  wire logic                     i_cmd_secure_queue,
    output logic                          o_cmd_ready,
    // Unit configuration
    input  wire logic                     i_translation_enable,
    input  wire logic [5:0]               i_stream_id_width,
    input  wire logic [5:0]               i_secure_stream_id_width,
    input  wire logic [4:0]               i_substream_id_width,
    input  wire logic                     i_secure_side_present,
    input  wire logic                     i_secure_stage2_present,
    // Status
    output logic [tcp_pkg::IDX_W-1:0]     o_queue_consumer_index,
    output logic                          o_illegal_command_error,
    input  wire logic                     i_error_clear,
    output logic                          o_sync_done,
    output logic                          o_busy,
    // Stream table entry lookup
    output logic                          o_lookup_req,
    output logic [31:0]                   o_lookup_sid,
    output logic                          o_lookup_secure,
    input  wire logic                     i_lookup_ack,
    input  wire logic                     i_ent_valid,
    input  wire logic                     i_ent_s1_en,
    input  wire logic                     i_ent_s2_en,
    input  wire logic                     i_ent_s1_bypass,
    input  wire logic                     i_ent_single_context,
    input  wire logic                     i_ent_hw_flag_update,
    input  wire logic [6:0]               i_ent_virtual_address_size,
    input  wire logic [6:0]               i_ent_input_address_size,
    // Prefetch request
    output logic                          o_pf_req,
    output logic                          o_pf_kind_addr,
    output logic [63:0]                   o_pf_addr,
    output logic                          o_pf_stage2_input,
    output logic [31:0]                   o_pf_sid,
    output logic                          o_pf_secure,
    output logic [19:0]                   o_pf_ssid,
    output logic                          o_pf_substream_valid,
    output logic                          o_pf_nonsecure_attribute,
    output logic                          o_pf_set_access_flag,
    output logic                          o_pf_speculative,
    input  wire logic                     i_pf_ack
);

    // Parameter out of range against an implemented width
    function automatic logic id_oor(input logic [31:0] id, input logic [5:0] w);
        logic res;
        res = 1'b0;
        if (w < 6'h20) begin
            res = ((id >> w) != 32'h0);
        end
        return res;
    endfunction : id_oor

    // Last walk index, capped so one command cannot run unbounded
    function automatic logic [tcp_pkg::OPS_W-1:0] ops_last(input logic [4:0] sz);
        logic [tcp_pkg::OPS_W-1:0] res;
        res = tcp_pkg::OPS_MAX_LAST;
        if (sz < 5'(tcp_pkg::MAX_OPS_LOG2)) begin
            res = 5'((5'h01 << sz) - 5'h01);
        end
        return res;
    endfunction : ops_last

    tcp_pkg::tcp_state_t state_reg, state_next;
    logic [tcp_pkg::IDX_W-1:0] idx_reg, idx_next;
    logic        err_reg, err_next;
    logic        sync_reg, sync_next;
    logic        kaddr_reg, kaddr_next;
    logic [31:0] sid_reg, sid_next;
    logic        sec_reg, sec_next;
    logic [19:0] ssid_reg, ssid_next;
    logic        ssv_reg, ssv_next;
    logic [4:0]  last_reg, last_next;
    logic        nsa_reg, nsa_next;
    logic [51:0] base_reg, base_next;
    logic [4:0]  n_reg, n_next;
    logic        s1_reg, s1_next;
    logic        s2_reg, s2_next;
    logic        byp_reg, byp_next;
    logic        hw_reg, hw_next;
    logic [6:0]  vas_reg, vas_next;
    logic [6:0]  ias_reg, ias_next;
    logic        lk_reg, lk_next;
    logic        pf_reg, pf_next;
    logic [63:0] pa_reg, pa_next;
    logic        s2in_reg, s2in_next;
    logic        pnsa_reg, pnsa_next;
    logic        setaf_reg, setaf_next;

    logic [7:0]  opc;
    logic        is_pf;
    logic        sel;
    logic        ssv_in;
    logic        strm_sec;
    logic [5:0]  sid_w;
    logic        rsv_bad;
    logic        illegal;
    logic        no_effect;
    logic        accept;
    logic [63:0] cand_va;
    logic [63:0] cand_out;
    logic        cand_oor;
    logic        s2in;

    // Field decode of the queue head
    assign opc      = i_cmd_data[tcp_pkg::OPC_LSB +: tcp_pkg::OPC_W];
    assign sel      = i_cmd_data[tcp_pkg::STREAM_SECURITY_SELECT_POS];
    assign is_pf    = (opc == tcp_pkg::OPC_PF_CFG) || (opc == tcp_pkg::OPC_PF_ADDR);
    assign strm_sec = i_cmd_secure_queue && i_secure_side_present && sel;
    assign sid_w    = strm_sec ? i_secure_stream_id_width : i_stream_id_width;
    // Without substreams the flag is dropped instead of rejected
    assign ssv_in   = i_cmd_data[tcp_pkg::SSV_POS] && (i_substream_id_width != 5'h00);

    // Reserved fields of prefetch commands are checked rather than ignored; sync ignores all its reserved fields
    always_comb begin
        rsv_bad = |i_cmd_data[tcp_pkg::RSV_LO_LSB +: tcp_pkg::RSV_LO_W];
        if (opc == tcp_pkg::OPC_PF_CFG) begin
            rsv_bad = rsv_bad || (|i_cmd_data[tcp_pkg::HI_LSB +: tcp_pkg::HI_W]);
        end else begin
            rsv_bad = rsv_bad || i_cmd_data[tcp_pkg::RSV_HI_POS];
        end
    end

    // Errors take precedence over the no-effect cases
    assign illegal = !(is_pf || (opc == tcp_pkg::OPC_SYNC))
                   || (is_pf && rsv_bad)
                   || (is_pf && !i_cmd_secure_queue && sel)
                   || ((opc == tcp_pkg::OPC_PF_ADDR)
                       && (i_cmd_data[tcp_pkg::STRIDE_LSB +: tcp_pkg::STRIDE_W] != 5'h00));
    assign no_effect = !i_translation_enable
                     || id_oor(i_cmd_data[tcp_pkg::SID_LSB +: tcp_pkg::SID_W], sid_w)
                     || (ssv_in && id_oor({12'h000, i_cmd_data[tcp_pkg::SSID_LSB +: tcp_pkg::SSID_W]},
                                          {1'b0, i_substream_id_width}));
    assign o_cmd_ready = (state_reg == tcp_pkg::ST_IDLE) && !err_reg;
    assign accept      = i_cmd_valid && o_cmd_ready;

    // Walk address and its stage 2 input form
    assign cand_va  = {base_reg, 12'h000} + 64'({n_reg, 12'h000});
    assign s2in     = s2_reg && (!s1_reg || byp_reg);
    assign cand_out = s2in ? {12'h000, cand_va[tcp_pkg::PA_HI:tcp_pkg::PAGE_SHIFT], 12'h000}
                           : cand_va;

    tcp_addr_range u_range (
        .i_va                   (cand_va),
        .i_s1_en                (s1_reg && !byp_reg),
        .i_s2_en                (s2_reg),
        .i_virtual_address_size (vas_reg),
        .i_input_address_size   (ias_reg),
        .o_out_of_range         (cand_oor)
    );

    // Next state of the interpreter
    always_comb begin
        state_next = state_reg;
        idx_next   = idx_reg;
        err_next   = err_reg && !i_error_clear;
        sync_next  = 1'b0;
        kaddr_next = kaddr_reg;
        sid_next   = sid_reg;
        sec_next   = sec_reg;
        ssid_next  = ssid_reg;
        ssv_next   = ssv_reg;
        last_next  = last_reg;
        nsa_next   = nsa_reg;
        base_next  = base_reg;
        n_next     = n_reg;
        s1_next    = s1_reg;
        s2_next    = s2_reg;
        byp_next   = byp_reg;
        hw_next    = hw_reg;
        vas_next   = vas_reg;
        ias_next   = ias_reg;
        lk_next    = lk_reg;
        pf_next    = pf_reg;
        pa_next    = pa_reg;
        s2in_next  = s2in_reg;
        pnsa_next  = pnsa_reg;
        setaf_next = setaf_reg;
        unique case (state_reg)
            tcp_pkg::ST_IDLE: begin
                if (accept) begin
                    if (illegal) begin
                        err_next = 1'b1;
                    end else begin
                        // Head has been read, so it counts as consumed
                        idx_next = tcp_pkg::IDX_W'(idx_reg + 20'h00001);
                        // Serial engine: idle means every earlier command is done
                        sync_next  = (opc == tcp_pkg::OPC_SYNC);
                        kaddr_next = (opc == tcp_pkg::OPC_PF_ADDR);
                        sid_next   = i_cmd_data[tcp_pkg::SID_LSB +: tcp_pkg::SID_W];
                        sec_next   = strm_sec;
                        ssid_next  = i_cmd_data[tcp_pkg::SSID_LSB +: tcp_pkg::SSID_W];
                        ssv_next   = ssv_in;
                        last_next  = ops_last(i_cmd_data[tcp_pkg::SIZE_LSB +: tcp_pkg::SIZE_W]);
                        nsa_next   = (opc == tcp_pkg::OPC_PF_ADDR) && i_cmd_data[tcp_pkg::NSA_POS];
                        base_next  = (opc == tcp_pkg::OPC_PF_ADDR)
                                   ? i_cmd_data[tcp_pkg::VA_LSB +: tcp_pkg::VA_W] : 52'h0;
                        n_next     = 5'h00;
                        if (is_pf && !no_effect) begin
                            lk_next    = 1'b1;
                            state_next = tcp_pkg::ST_LOOKUP;
                        end
                    end
                end
            end
            tcp_pkg::ST_LOOKUP: begin
                if (i_lookup_ack) begin
                    lk_next  = 1'b0;
                    s1_next  = i_ent_s1_en;
                    s2_next  = i_ent_s2_en;
                    byp_next = i_ent_s1_bypass;
                    hw_next  = i_ent_hw_flag_update;
                    vas_next = i_ent_virtual_address_size;
                    ias_next = i_ent_input_address_size;
                    ssv_next = ssv_reg && !i_ent_single_context;
                    // Invalid or missing entry: drop quietly
                    state_next = i_ent_valid ? tcp_pkg::ST_ISSUE : tcp_pkg::ST_IDLE;
                end
            end
            tcp_pkg::ST_ISSUE: begin
                if (!kaddr_reg) begin
                    pf_next    = 1'b1;
                    pa_next    = 64'h0;
                    s2in_next  = 1'b0;
                    pnsa_next  = 1'b0;
                    setaf_next = s1_reg && s2_reg && hw_reg;
                    state_next = tcp_pkg::ST_WAIT;
                end else if (cand_oor) begin
                    // Out-of-range page skipped, no fault recorded
                    if (n_reg == last_reg) begin
                        state_next = tcp_pkg::ST_IDLE;
                    end else begin
                        n_next = n_reg + 5'h01;
                    end
                end else begin
                    pf_next    = 1'b1;
                    pa_next    = cand_out;
                    s2in_next  = s2in;
                    pnsa_next  = nsa_reg && sec_reg && s2in;
                    setaf_next = hw_reg;
                    state_next = tcp_pkg::ST_WAIT;
                end
            end
            tcp_pkg::ST_WAIT: begin
                if (i_pf_ack) begin
                    pf_next = 1'b0;
                    if (!kaddr_reg || (n_reg == last_reg)) begin
                        state_next = tcp_pkg::ST_IDLE;
                    end else begin
                        n_next     = n_reg + 5'h01;
                        state_next = tcp_pkg::ST_ISSUE;
                    end
                end
            end
        endcase
    end

    // State registers
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            state_reg <= tcp_pkg::ST_IDLE;
            idx_reg   <= tcp_pkg::IDX_RST;
            err_reg   <= 1'b0;
            sync_reg  <= 1'b0;
            kaddr_reg <= 1'b0;
            sid_reg   <= 32'h0;
            sec_reg   <= 1'b0;
            ssid_reg  <= 20'h0;
            ssv_reg   <= 1'b0;
            last_reg  <= 5'h00;
            nsa_reg   <= 1'b0;
            base_reg  <= 52'h0;
            n_reg     <= 5'h00;
            s1_reg    <= 1'b0;
            s2_reg    <= 1'b0;
            byp_reg   <= 1'b0;
            hw_reg    <= 1'b0;
            vas_reg   <= 7'h00;
            ias_reg   <= 7'h00;
            lk_reg    <= 1'b0;
            pf_reg    <= 1'b0;
            pa_reg    <= 64'h0;
            s2in_reg  <= 1'b0;
            pnsa_reg  <= 1'b0;
            setaf_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            idx_reg   <= idx_next;
            err_reg   <= err_next;
            sync_reg  <= sync_next;
            kaddr_reg <= kaddr_next;
            sid_reg   <= sid_next;
            sec_reg   <= sec_next;
            ssid_reg  <= ssid_next;
            ssv_reg   <= ssv_next;
            last_reg  <= last_next;
            nsa_reg   <= nsa_next;
            base_reg  <= base_next;
            n_reg     <= n_next;
            s1_reg    <= s1_next;
            s2_reg    <= s2_next;
            byp_reg   <= byp_next;
            hw_reg    <= hw_next;
            vas_reg   <= vas_next;
            ias_reg   <= ias_next;
            lk_reg    <= lk_next;
            pf_reg    <= pf_next;
            pa_reg    <= pa_next;
            s2in_reg  <= s2in_next;
            pnsa_reg  <= pnsa_next;
            setaf_reg <= setaf_next;
        end
    end

    // Outputs, all from flops
    assign o_queue_consumer_index   = idx_reg;
    assign o_illegal_command_error  = err_reg;
    assign o_sync_done              = sync_reg;
    assign o_busy                   = (state_reg != tcp_pkg::ST_IDLE);
    assign o_lookup_req             = lk_reg;
    assign o_lookup_sid             = sid_reg;
    assign o_lookup_secure          = sec_reg;
    assign o_pf_req                 = pf_reg;
    assign o_pf_kind_addr           = kaddr_reg;
    assign o_pf_addr                = pa_reg;
    assign o_pf_stage2_input        = s2in_reg;
    assign o_pf_sid                 = sid_reg;
    assign o_pf_secure              = sec_reg;
    assign o_pf_ssid                = ssid_reg;
    assign o_pf_substream_valid     = ssv_reg;
    assign o_pf_nonsecure_attribute = pnsa_reg;
    assign o_pf_set_access_flag     = setaf_reg;
    assign o_pf_speculative         = kaddr_reg;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);

    AST_CONS_AFTER_READ: assert property (
        (idx_reg != $past(idx_reg)) |-> $past(accept) && (idx_reg == $past(idx_reg) + 20'h00001))
        else $error("consumer index moved without a read");
    AST_NONSEC_SEL_ILLEGAL: assert property (
        (accept && is_pf && !i_cmd_secure_queue && sel) |=> err_reg && $stable(idx_reg))
        else $error("security select on non-secure queue not rejected");
    AST_STRIDE_ILLEGAL: assert property (
        (accept && (opc == tcp_pkg::OPC_PF_ADDR)
         && (i_cmd_data[tcp_pkg::STRIDE_LSB +: tcp_pkg::STRIDE_W] != 5'h00)) |=> err_reg)
        else $error("non-zero stride not rejected");
    AST_DISABLED_NO_PF: assert property (
        (accept && !illegal && !i_translation_enable) |=> !lk_reg [*2] ##0 !pf_reg)
        else $error("prefetch started while translation disabled");
    AST_SYNC_AFTER_IDLE: assert property (
        sync_reg |-> $past(state_reg == tcp_pkg::ST_IDLE) && !pf_reg && !lk_reg)
        else $error("sync completed with work outstanding");
    AST_OPS_CAPPED: assert property (
        pf_reg |-> (n_reg <= tcp_pkg::OPS_MAX_LAST) && (n_reg <= last_reg))
        else $error("prefetch walk exceeded cap");
    AST_PAGE_ALIGNED: assert property (
        pf_reg |-> (pa_reg[11:0] == 12'h000))
        else $error("prefetch address not page aligned");
    AST_IPA_WIDTH: assert property (
        (pf_reg && s2in_reg) |-> (pa_reg[63:52] == 12'h000))
        else $error("stage 2 input address above bit 51");
    AST_NSA_SECURE_ONLY: assert property (
        pnsa_reg |-> sec_reg && s2in_reg && kaddr_reg)
        else $error("non-secure attribute forwarded for wrong stream");
    AST_REQ_HELD: assert property (
        (pf_reg && !i_pf_ack) |=> pf_reg && $stable(pa_reg))
        else $error("prefetch request dropped before ack");
    AST_ERR_NO_CONSUME: assert property (
        (accept && illegal) |=> err_reg && !o_cmd_ready && (idx_reg == $past(idx_reg)))
        else $error("illegal command consumed");

endmodule : tcp_prefetch_engine

// ---- inc/tcp_pkg.sv ----
package tcp_pkg;

    // Opcodes handled by this interpreter
    localparam logic [7:0] OPC_PF_CFG  = 8'h01;
    localparam logic [7:0] OPC_PF_ADDR = 8'h02;
    localparam logic [7:0] OPC_SYNC    = 8'h46;

    // Command word layout, bit positions in the 128-bit entry
    localparam int CMD_W      = 128;
    localparam int OPC_LSB    = 0;
    localparam int OPC_W      = 8;
    localparam int RSV_LO_LSB = 8;
    localparam int RSV_LO_W   = 2;
    localparam int STREAM_SECURITY_SELECT_POS   = 10;
    localparam int SSV_POS    = 11;
    localparam int SSID_LSB   = 12;
    localparam int SSID_W     = 20;
    localparam int SID_LSB    = 32;
    localparam int SID_W      = 32;
    localparam int HI_LSB     = 64;
    localparam int HI_W       = 64;
    localparam int SIZE_LSB   = 64;
    localparam int SIZE_W     = 5;
    localparam int STRIDE_LSB = 69;
    localparam int STRIDE_W   = 5;
    localparam int RSV_HI_POS = 74;
    localparam int NSA_POS    = 75;
    localparam int VA_LSB     = 76;
    localparam int VA_W       = 52;

    // Address forms
    localparam int PAGE_SHIFT = 12;
    localparam int PA_HI      = 51;
    localparam int PA_W       = 40;

    // Prefetch operation cap and counter
    localparam int             MAX_OPS_LOG2 = 4;
    localparam int             OPS_W        = 5;
    localparam logic [OPS_W-1:0] OPS_MAX_LAST = 5'h0F;

    // Consumer index
    localparam int                IDX_W   = 20;
    localparam logic [IDX_W-1:0]  IDX_RST = 20'h00000;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_LOOKUP,
        ST_ISSUE,
        ST_WAIT
    } tcp_state_t;

endpackage : tcp_pkg

// ---- design/tcp_addr_range.sv ----
`timescale 1ns/10ps
// Range test of one prefetch address against the stream's address sizes
module tcp_addr_range (
    // Address under test
    input  wire logic [63:0] i_va,
    // Stream translation setup
    input  wire logic        i_s1_en,
    input  wire logic        i_s2_en,
    input  wire logic [6:0]  i_virtual_address_size,
    input  wire logic [6:0]  i_input_address_size,
    // Verdict
    output logic             o_out_of_range
);

    logic [6:0]  s1_sh;
    logic [63:0] s1_hi;
    logic [63:0] s1_ones;
    logic [63:0] s2_hi;
    logic        s1_bad;
    logic        s2_bad;

    // Stage 1: bits from size-1 upward all equal; stage 2: bits from size upward zero
    always_comb begin
        s1_sh = (i_virtual_address_size == 7'h00) ? 7'h00 : i_virtual_address_size - 7'h01;
        s1_hi   = (s1_sh > 7'h3F) ? 64'h0 : (i_va >> s1_sh);
        s1_ones = (s1_sh > 7'h3F) ? 64'h0 : ({64{1'b1}} >> s1_sh);
        s2_hi   = (i_input_address_size > 7'h3F) ? 64'h0 : (i_va >> i_input_address_size);
        s1_bad  = i_s1_en && (s1_hi != 64'h0) && (s1_hi != s1_ones);
        s2_bad  = i_s2_en && (s2_hi != 64'h0);
        o_out_of_range = s1_bad || s2_bad;
    end

endmodule : tcp_addr_range

// ---- dv/tcp_mem_model.sv ----
`timescale 1ns/10ps
// Far-side responder: answers entry lookups and prefetches after a set wait
module tcp_mem_model (
    // Clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_srst,
    // Requests and wait length
    input  wire logic       i_lookup_req,
    input  wire logic       i_pf_req,
    input  wire logic [3:0] i_delay,
    // One-cycle answers
    output logic            o_lookup_ack,
    output logic            o_pf_ack
);
    logic [3:0] wait_reg;
    // Restart on every answer, so a held request is answered again only after a fresh wait
    always_ff @(posedge i_mclk) begin
        if (i_srst || o_lookup_ack || o_pf_ack || !(i_lookup_req || i_pf_req)) begin
            wait_reg <= 4'h0;
        end else begin
            wait_reg <= wait_reg + 4'h1;
        end
    end
    // Slow or prompt answers, chosen by the bench per command
    assign o_lookup_ack = i_lookup_req && (wait_reg == i_delay);
    assign o_pf_ack     = i_pf_req && (wait_reg == i_delay);
endmodule : tcp_mem_model

// ---- dv/tb.sv ----
`timescale 1ns/10ps
module tb;
    typedef struct packed {logic [127:0] c; logic [1:0] q; logic [5:0] e; logic [5:0] x;} tcp_row_t;
    logic                      i_mclk = 1'b0, i_srst = 1'b1, i_cmd_valid = 1'b0;
    logic [tcp_pkg::CMD_W-1:0] i_cmd_data = 128'h0;
    logic                      i_cmd_secure_queue = 1'b0, i_translation_enable = 1'b0;
    logic                      i_error_clear = 1'b0, i_lookup_ack, i_pf_ack;
    logic [5:0]                ent = 6'h00;
    logic [3:0]                dly = 4'h0;
    logic [5:0]                sidw = 6'h08;
    logic [4:0]                ssw = 5'h08;
    logic [31:0]               o_pf_sid;
    logic [19:0]               o_queue_consumer_index, exp_idx = 20'h0;
    logic                      o_illegal_command_error, o_sync_done, o_busy, o_lookup_req;
    logic                      o_pf_req, o_pf_kind_addr, o_pf_set_access_flag;
    logic [63:0]               o_pf_addr, base = 64'h0;
    int                        miscompares = 0, total_checks = 0, pf_cnt = 0, sd_cnt = 0;
    tcp_row_t                  rows [16];
    tcp_prefetch_engine uut (.i_mclk, .i_srst, .i_cmd_valid, .i_cmd_data, .i_cmd_secure_queue,
        .o_cmd_ready(), .i_translation_enable, .i_stream_id_width(sidw),
        .i_secure_stream_id_width(6'h08), .i_substream_id_width(ssw),
        .i_secure_side_present(1'b1), .i_secure_stage2_present(1'b1), .o_queue_consumer_index,
        .o_illegal_command_error, .i_error_clear, .o_sync_done, .o_busy, .o_lookup_req,
        .o_lookup_sid(), .o_lookup_secure(), .i_lookup_ack, .i_ent_valid(ent[5]),
        .i_ent_s1_en(ent[4]), .i_ent_s2_en(ent[3]), .i_ent_s1_bypass(ent[2]),
        .i_ent_single_context(ent[1]), .i_ent_hw_flag_update(ent[0]),
        .i_ent_virtual_address_size(7'h30), .i_ent_input_address_size(7'h30), .o_pf_req,
        .o_pf_kind_addr, .o_pf_addr, .o_pf_stage2_input(), .o_pf_sid, .o_pf_secure(),
        .o_pf_ssid(), .o_pf_substream_valid(), .o_pf_nonsecure_attribute(),
        .o_pf_set_access_flag, .o_pf_speculative(), .i_pf_ack);
    tcp_mem_model peer (.i_mclk, .i_srst, .i_lookup_req(o_lookup_req), .i_pf_req(o_pf_req),
        .i_delay(dly), .o_lookup_ack(i_lookup_ack), .o_pf_ack(i_pf_ack));
    // Free-running clock
    always #10 i_mclk = ~i_mclk;
    // Count finished prefetches and barrier pulses; page addresses step by 4 KB
    always @(posedge i_mclk) begin
        if (o_sync_done === 1'b1) sd_cnt++;
        if (o_pf_req === 1'b1 && i_pf_ack === 1'b1) begin
            if (o_pf_kind_addr === 1'b1) chk("pf_addr", base + 64'(pf_cnt) * 64'h1000, o_pf_addr);
            chk("access_flag", 64'(ent[0] && (o_pf_kind_addr || (ent[4] && ent[3]))),
                o_pf_set_access_flag);
            chk("pf_sid", i_cmd_data[63:32], o_pf_sid);
            pf_cnt++;
        end
    end
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict
    function automatic tcp_row_t rw(logic [63:0] h, logic [31:0] s, logic [31:0] l,
                                    logic [1:0] q, logic [5:0] e, logic [5:0] x);
        return '{{h, s, l}, q, e, x};
    endfunction : rw
    // One command in, wait until idle, then compare; an error is cleared afterwards
    task automatic run(input tcp_row_t r);
        int n;
        @(posedge i_mclk);
        #1;
        {i_cmd_data, i_cmd_secure_queue, i_translation_enable, ent} = {r.c, r.q, r.e};
        i_cmd_valid = 1'b1;
        pf_cnt = 0;
        sd_cnt = 0;
        base = {r.c[127:76], 12'h000};
        exp_idx += 20'(!r.x[5]);
        @(posedge i_mclk);
        #1;
        i_cmd_valid = 1'b0;
        for (n = 0; n < 300 && o_busy !== 1'b0; n++) begin
            @(posedge i_mclk);
            #1;
        end
        if (n == 300) begin
            miscompares++;
            print_verdict();
        end
        @(posedge i_mclk);
        #1;
        chk("error", r.x[5], o_illegal_command_error);
        chk("index", exp_idx, o_queue_consumer_index);
        chk("prefetches", r.x[4:0], pf_cnt);
        chk("sync", !r.x[5] && r.c[7:0] == 8'h46, sd_cnt);
        i_error_clear = r.x[5];
        @(posedge i_mclk);
        #1;
        i_error_clear = 1'b0;
        $display("test done: command %h", r.c);
    endtask : run
    // Rows: high word, stream, low word, {secure queue, enable}, entry, {error, count}
    initial begin
        rows = '{rw(64'h0, 32'h0, 32'h46, 2'h1, 6'h39, 6'h00),
            rw(64'h0, 32'h5, 32'h1, 2'h1, 6'h39, 6'h01), rw(64'h0, 32'h5, 32'h1, 2'h0, 6'h39, 6'h00),
            rw(64'h12345002, 32'h5, 32'h2, 2'h1, 6'h39, 6'h04),
            rw(64'h12345005, 32'h5, 32'h2, 2'h1, 6'h39, 6'h10),
            rw(64'h12345022, 32'h5, 32'h2, 2'h1, 6'h39, 6'h20),
            rw(64'h0, 32'h5, 32'h401, 2'h1, 6'h39, 6'h20), rw(64'h0, 32'h5, 32'h401, 2'h3, 6'h39, 6'h01),
            rw(64'h0, 32'h5, 32'h101, 2'h1, 6'h39, 6'h20), rw(64'h0, 32'h5, 32'h3, 2'h1, 6'h39, 6'h20),
            rw(64'h1, 32'h5, 32'h1, 2'h1, 6'h39, 6'h20), rw(64'h0, 32'h100, 32'h1, 2'h1, 6'h39, 6'h00),
            rw(64'h1000000012345000, 32'h5, 32'h2, 2'h1, 6'h39, 6'h00),
            rw(64'h0, 32'h5, 32'h1, 2'h1, 6'h19, 6'h00),
            rw(64'h0, 32'h5, 32'h00100801, 2'h1, 6'h39, 6'h00),
            rw(64'h0, 32'h5, 32'h00003801, 2'h1, 6'h3B, 6'h01)};
        repeat (5) @(posedge i_mclk);
        #1;
        i_srst = 1'b0;
        foreach (rows[i]) begin
            dly = 4'(i % 3);
            run(rows[i]);
        end
        // Width-dependent cases: secure ids use their own width, then no substreams
        sidw = 6'h10;
        run(rw(64'h0, 32'h100, 32'h401, 2'h3, 6'h39, 6'h00));
        run(rw(64'h0, 32'h100, 32'h1, 2'h3, 6'h38, 6'h01));
        ssw = 5'h00;
        run(rw(64'h0, 32'h5, 32'h00100801, 2'h1, 6'h39, 6'h01));
        // Two barriers on consecutive edges, then a reset in mid-run
        i_cmd_data = 128'h46;
        i_cmd_valid = 1'b1;
        repeat (2) @(posedge i_mclk);
        #1;
        i_cmd_valid = 1'b0;
        chk("b2b_index", exp_idx + 20'h2, o_queue_consumer_index);
        i_srst = 1'b1;
        repeat (2) @(posedge i_mclk);
        #1;
        i_srst = 1'b0;
        chk("reset_index", 64'h0, o_queue_consumer_index);
        chk("reset_error", 64'h0, o_illegal_command_error);
        $display("test done: back to back and reset");
        print_verdict();
    end
endmodule : tb
